// >>> design/cthtg_pkg.sv
// package: register map, field layout and types of the crt/tv horizontal timing block
package cthtg_pkg;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses on the plain register port)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_HACT = 8'h50;
  localparam logic [7:0] ADDR_HBLANK = 8'h52;
  localparam logic [7:0] ADDR_HSS = 8'h53;
  localparam logic [7:0] ADDR_HSW_POL = 8'h54;
  localparam logic [7:0] ADDR_VH_LO = 8'h56;
  localparam logic [7:0] ADDR_VH_HI = 8'h57;
  localparam logic [7:0] ADDR_OUT_CTRL = 8'h5B;
  localparam logic [7:0] ADDR_MODE = 8'h60;
  localparam logic [7:0] ADDR_STATUS = 8'h61;
  localparam logic [7:0] ADDR_LINE_LO = 8'h62;
  localparam logic [7:0] ADDR_LINE_HI = 8'h63;

  // ----------------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------------
  localparam int HACT_W = 7;
  localparam int HBLANK_W = 6;
  localparam int HSS_W = 6;
  localparam int HSW_W = 4;
  localparam int HSYNC_POL_BIT = 7;
  localparam int VH_W = 10;
  localparam int PAL_BIT = 0;
  localparam logic [7:0] OUT_CTRL_MASK = 8'h3B;
  localparam int MODE_TV_BIT = 0;
  localparam int MODE_DEPTH16_BIT = 1;
  localparam int ST_HBLANK_BIT = 0;
  localparam int ST_HSYNC_BIT = 1;
  localparam int ST_LAST_LINE_BIT = 2;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int PX_W = 11;

  // pixel add-ons applied after the 8-pixel multiply
  localparam logic [3:0] ADD_UNIT = 4'h8;
  localparam logic [3:0] ADD_BLANK_NTSC = 4'h6;
  localparam logic [3:0] ADD_BLANK_PAL = 4'h7;
  localparam logic [3:0] ADD_SS_CRT8 = 4'h3;
  localparam logic [3:0] ADD_SS_CRT16 = 4'h5;
  localparam logic [3:0] ADD_SS_TV8 = 4'h1;
  localparam logic [3:0] ADD_SS_TV16 = 4'h3;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {CTHTG_OUT_CRT, CTHTG_OUT_NTSC, CTHTG_OUT_PAL} cthtg_out_t;
  typedef enum logic {CTHTG_PH_ACTIVE, CTHTG_PH_BLANK} cthtg_phase_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cthtg_bus_req_t;

  typedef struct packed {
    logic [HACT_W-1:0] hact;
    logic [HBLANK_W-1:0] hblank;
    logic [HSS_W-1:0] hss;
    logic [HSW_W-1:0] hsw;
    logic hpol;
    logic [VH_W-1:0] vh;
    logic tv;
    logic pal;
    logic depth16;
  } cthtg_cfg_t;

endpackage

// >>> design/cthtg_top.sv
// crt/tv horizontal timing generator with its configuration registers
`timescale 1ns/10ps

module cthtg_top (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire cthtg_pkg::cthtg_bus_req_t bus_req,
  output logic [7:0] rd_data,
  output logic horiz_sync_out,
  output logic disp_en_out,
  output logic line_start_out
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // a field in 8-pixel units plus a small pixel add-on
  function automatic logic [cthtg_pkg::PX_W-1:0] px8(input logic [6:0] field,
                                                       input logic [3:0] add);
    px8 = {1'b0, field, 3'b000} + {7'h00, add};
  endfunction

  // output type from the tv and format bits
  function automatic cthtg_pkg::cthtg_out_t out_type(input logic tv, input logic pal);
    if (!tv) begin
      out_type = cthtg_pkg::CTHTG_OUT_CRT;
    end else if (pal) begin
      out_type = cthtg_pkg::CTHTG_OUT_PAL;
    end else begin
      out_type = cthtg_pkg::CTHTG_OUT_NTSC;
    end
  endfunction

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  logic [cthtg_pkg::HACT_W-1:0] hact_ff;
  logic [cthtg_pkg::HBLANK_W-1:0] hblank_ff;
  logic [cthtg_pkg::HSS_W-1:0] hss_ff;
  logic [cthtg_pkg::HSW_W-1:0] hsw_ff;
  logic hpol_ff;
  logic [cthtg_pkg::VH_W-1:0] vh_ff;
  logic [7:0] out_ctrl_ff;
  logic tv_ff;
  logic depth16_ff;
  cthtg_pkg::cthtg_cfg_t cfg;

  // software writes; one register per aligned offset, unmapped writes are dropped
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      hact_ff <= cthtg_pkg::REG_RESET[cthtg_pkg::HACT_W-1:0];
      hblank_ff <= cthtg_pkg::REG_RESET[cthtg_pkg::HBLANK_W-1:0];
      hss_ff <= cthtg_pkg::REG_RESET[cthtg_pkg::HSS_W-1:0];
      hsw_ff <= cthtg_pkg::REG_RESET[cthtg_pkg::HSW_W-1:0];
      hpol_ff <= 1'b0;
      vh_ff <= {cthtg_pkg::REG_RESET[1:0], cthtg_pkg::REG_RESET};
      out_ctrl_ff <= cthtg_pkg::REG_RESET;
      tv_ff <= 1'b0;
      depth16_ff <= 1'b0;
    end else if (bus_req.wr) begin
      unique case (bus_req.addr)
        cthtg_pkg::ADDR_HACT: begin
          hact_ff <= bus_req.wdata[cthtg_pkg::HACT_W-1:0];
        end
        cthtg_pkg::ADDR_HBLANK: begin
          hblank_ff <= bus_req.wdata[cthtg_pkg::HBLANK_W-1:0];
        end
        cthtg_pkg::ADDR_HSS: begin
          hss_ff <= bus_req.wdata[cthtg_pkg::HSS_W-1:0];
        end
        cthtg_pkg::ADDR_HSW_POL: begin
          hsw_ff <= bus_req.wdata[cthtg_pkg::HSW_W-1:0];
          hpol_ff <= bus_req.wdata[cthtg_pkg::HSYNC_POL_BIT];
        end
        cthtg_pkg::ADDR_VH_LO: begin
          vh_ff[7:0] <= bus_req.wdata;
        end
        cthtg_pkg::ADDR_VH_HI: begin
          vh_ff[9:8] <= bus_req.wdata[1:0];
        end
        cthtg_pkg::ADDR_OUT_CTRL: begin
          out_ctrl_ff <= bus_req.wdata & cthtg_pkg::OUT_CTRL_MASK;
        end
        cthtg_pkg::ADDR_MODE: begin
          tv_ff <= bus_req.wdata[cthtg_pkg::MODE_TV_BIT];
          depth16_ff <= bus_req.wdata[cthtg_pkg::MODE_DEPTH16_BIT];
        end
        default: begin
          // read-only and unmapped offsets ignore writes
        end
      endcase
    end
  end

  // gather the fields the timing logic uses
  always_comb begin
    cfg.hact = hact_ff;
    cfg.hblank = hblank_ff;
    cfg.hss = hss_ff;
    cfg.hsw = hsw_ff;
    cfg.hpol = hpol_ff;
    cfg.vh = vh_ff;
    cfg.tv = tv_ff;
    cfg.pal = out_ctrl_ff[cthtg_pkg::PAL_BIT];
    cfg.depth16 = depth16_ff;
  end

  // ----------------------------------------------------------------------
  // line geometry in pixels
  // ----------------------------------------------------------------------
  cthtg_pkg::cthtg_out_t otype;
  logic [cthtg_pkg::PX_W-1:0] act_len;
  logic [cthtg_pkg::PX_W-1:0] blank_len;
  logic [cthtg_pkg::PX_W-1:0] sync_start;
  logic [cthtg_pkg::PX_W-1:0] sync_len;
  logic [cthtg_pkg::PX_W-1:0] sync_end;

  // all lengths are at least one pixel, so len - 1 never wraps
  always_comb begin
    otype = out_type(cfg.tv, cfg.pal);
    act_len = px8(cfg.hact, cthtg_pkg::ADD_UNIT);
    sync_len = px8({3'b000, cfg.hsw}, cthtg_pkg::ADD_UNIT);
    unique case (otype)
      cthtg_pkg::CTHTG_OUT_CRT: begin
        blank_len = px8({1'b0, cfg.hblank}, cthtg_pkg::ADD_UNIT);
        sync_start = px8({1'b0, cfg.hss}, cfg.depth16 ? cthtg_pkg::ADD_SS_CRT16
                                                      : cthtg_pkg::ADD_SS_CRT8);
      end
      cthtg_pkg::CTHTG_OUT_NTSC: begin
        blank_len = px8({1'b0, cfg.hblank}, cthtg_pkg::ADD_BLANK_NTSC);
        sync_start = px8({1'b0, cfg.hss}, cfg.depth16 ? cthtg_pkg::ADD_SS_TV16
                                                      : cthtg_pkg::ADD_SS_TV8);
      end
      cthtg_pkg::CTHTG_OUT_PAL: begin
        blank_len = px8({1'b0, cfg.hblank}, cthtg_pkg::ADD_BLANK_PAL);
        sync_start = px8({1'b0, cfg.hss}, cfg.depth16 ? cthtg_pkg::ADD_SS_TV16
                                                      : cthtg_pkg::ADD_SS_TV8);
      end
      default: begin
        // the spare enum code cannot be produced by out_type
        blank_len = px8({1'b0, cfg.hblank}, cthtg_pkg::ADD_UNIT);
        sync_start = px8({1'b0, cfg.hss}, cthtg_pkg::ADD_SS_CRT8);
      end
    endcase
    sync_end = sync_start + sync_len;
  end

  // ----------------------------------------------------------------------
  // pixel and line counters
  // ----------------------------------------------------------------------
  cthtg_pkg::cthtg_phase_t phase_ff;
  cthtg_pkg::cthtg_phase_t nxt_phase;
  logic [cthtg_pkg::PX_W-1:0] pix_ff;
  logic [cthtg_pkg::PX_W-1:0] nxt_pix;
  logic [cthtg_pkg::VH_W-1:0] line_ff;
  logic [cthtg_pkg::VH_W-1:0] nxt_line;
  logic line_wrap;

  // active region first, then blanking; >= keeps a shortened length from running away
  always_comb begin
    nxt_phase = phase_ff;
    nxt_pix = pix_ff + 11'h001;
    nxt_line = line_ff;
    line_wrap = 1'b0;
    unique case (phase_ff)
      cthtg_pkg::CTHTG_PH_ACTIVE: begin
        if (pix_ff >= act_len - 11'h001) begin
          nxt_phase = cthtg_pkg::CTHTG_PH_BLANK;
          nxt_pix = '0;
        end
      end
      cthtg_pkg::CTHTG_PH_BLANK: begin
        if (pix_ff >= blank_len - 11'h001) begin
          nxt_phase = cthtg_pkg::CTHTG_PH_ACTIVE;
          nxt_pix = '0;
          line_wrap = 1'b1;
          nxt_line = (line_ff >= cfg.vh) ? '0 : line_ff + 10'h001;
        end
      end
    endcase
  end

  // counter state; reset parks in blanking with the pixel count at all ones, past any blanking end, so the first edge after
  // release opens a full active region with its line start pulse, never a short line
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      phase_ff <= cthtg_pkg::CTHTG_PH_BLANK;
      pix_ff <= '1;
      line_ff <= '0;
    end else begin
      phase_ff <= nxt_phase;
      pix_ff <= nxt_pix;
      line_ff <= nxt_line;
    end
  end

  // ----------------------------------------------------------------------
  // video outputs
  // ----------------------------------------------------------------------
  logic sync_raw_ff;
  logic nxt_sync_raw;
  logic hsync_ff;
  logic disp_en_ff;
  logic line_start_ff;

  // sync window is measured from the first blanking pixel and never leaves blanking
  always_comb begin
    nxt_sync_raw = (nxt_phase == cthtg_pkg::CTHTG_PH_BLANK) &&
                   (nxt_pix >= sync_start) && (nxt_pix < sync_end);
  end

  // registered so the pins align with the counter state they describe
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sync_raw_ff <= 1'b0;
      hsync_ff <= 1'b1;
      disp_en_ff <= 1'b0;
      line_start_ff <= 1'b0;
    end else begin
      sync_raw_ff <= nxt_sync_raw;
      hsync_ff <= cfg.hpol ? nxt_sync_raw : ~nxt_sync_raw;
      disp_en_ff <= (nxt_phase == cthtg_pkg::CTHTG_PH_ACTIVE);
      line_start_ff <= line_wrap;
    end
  end

  assign horiz_sync_out = hsync_ff;
  assign disp_en_out = disp_en_ff;
  assign line_start_out = line_start_ff;

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd;

  // data stands only in the cycle after the read strobe; unmapped reads give zero
  always_comb begin
    nxt_rd = 8'h00;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        cthtg_pkg::ADDR_HACT: nxt_rd = {1'b0, hact_ff};
        cthtg_pkg::ADDR_HBLANK: nxt_rd = {2'b00, hblank_ff};
        cthtg_pkg::ADDR_HSS: nxt_rd = {2'b00, hss_ff};
        cthtg_pkg::ADDR_HSW_POL: nxt_rd = {hpol_ff, 3'b000, hsw_ff};
        cthtg_pkg::ADDR_VH_LO: nxt_rd = vh_ff[7:0];
        cthtg_pkg::ADDR_VH_HI: nxt_rd = {6'h00, vh_ff[9:8]};
        cthtg_pkg::ADDR_OUT_CTRL: nxt_rd = out_ctrl_ff;
        cthtg_pkg::ADDR_MODE: nxt_rd = {6'h00, depth16_ff, tv_ff};
        cthtg_pkg::ADDR_STATUS: begin
          nxt_rd[cthtg_pkg::ST_HBLANK_BIT] = (phase_ff == cthtg_pkg::CTHTG_PH_BLANK);
          nxt_rd[cthtg_pkg::ST_HSYNC_BIT] = sync_raw_ff;
          nxt_rd[cthtg_pkg::ST_LAST_LINE_BIT] = (line_ff >= cfg.vh);
        end
        cthtg_pkg::ADDR_LINE_LO: nxt_rd = line_ff[7:0];
        cthtg_pkg::ADDR_LINE_HI: nxt_rd = {6'h00, line_ff[9:8]};
        default: nxt_rd = 8'h00;
      endcase
    end
  end

  // read data register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rd_data_ff <= 8'h00;
    end else begin
      rd_data_ff <= nxt_rd;
    end
  end

  assign rd_data = rd_data_ff;

endmodule // cthtg_top

// >>> sim/cthtg_checker.sv
// checker: timing relations on the ports of the horizontal timing block
`timescale 1ns/10ps
module cthtg_checker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire cthtg_pkg::cthtg_bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  input wire logic horiz_sync_out,
  input wire logic disp_en_out,
  input wire logic line_start_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic pol_ff;
  logic pol_q1_ff;
  logic pol_q2_ff;
  logic pol_ok;
  logic sync_act;
  // ----------------------------------------------------------------------
  // polarity shadow
  // ----------------------------------------------------------------------
  // the pin level only reads as active or idle once a polarity write has settled
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pol_ff <= 1'b0;
      pol_q1_ff <= 1'b0;
      pol_q2_ff <= 1'b0;
    end else begin
      if (bus_req.wr && bus_req.addr == cthtg_pkg::ADDR_HSW_POL) begin
        pol_ff <= bus_req.wdata[cthtg_pkg::HSYNC_POL_BIT];
      end
      pol_q1_ff <= pol_ff;
      pol_q2_ff <= pol_q1_ff;
    end
  end
  assign pol_ok = (pol_ff == pol_q1_ff) && (pol_ff == pol_q2_ff);
  assign sync_act = (horiz_sync_out == pol_ff);
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  AST_ACT_MIN: assert property ($rose(disp_en_out) |-> disp_en_out [*8])
    else $error("active region shorter than 8 pixels");
  AST_BLANK_MIN: assert property ($fell(disp_en_out) |-> !disp_en_out [*6])
    else $error("blanking shorter than 6 pixels");
  AST_SYNC_IN_BLANK: assert property (disp_en_out && pol_ok |-> !sync_act)
    else $error("sync active during displayed pixels");
  AST_SYNC_NOT_AT_EDGE: assert property ($fell(disp_en_out) && pol_ok |-> !sync_act)
    else $error("sync active on first blanking pixel");
  // reset geometry clips the pulse to 5 pixels, so only that much is demanded here
  AST_SYNC_MIN: assert property ($rose(sync_act) && pol_ok |-> sync_act [*5])
    else $error("sync pulse too short");
  AST_LS_ON_RISE: assert property (line_start_out |-> disp_en_out && !$past(disp_en_out))
    else $error("line start away from active start");
  AST_LS_PULSE: assert property (line_start_out |=> !line_start_out)
    else $error("line start longer than one cycle");
  AST_RISE_LS: assert property ($rose(disp_en_out) && $past(rstn) |-> line_start_out)
    else $error("new line without line start");
  COV_LINE: cover property (line_start_out);
  COV_SYNC: cover property ($rose(sync_act) && pol_ok);
  COV_READ: cover property (bus_req.rd);
endmodule // cthtg_checker

// >>> sim/cthtg_video_sink.sv
// partner model: monitor or encoder input that measures each line
`timescale 1ns/10ps
module cthtg_video_sink (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic horiz_sync_out,
  input wire logic disp_en_out,
  input wire logic pol,
  output int act_len,
  output int blank_len,
  output int ss_off,
  output int sw_len,
  output int lines
);
  int a;
  int b;
  int w;
  // a line is recorded when the next active region begins; sync offset counts
  // from blanking pixel 0, the first cycle with the display enable low
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      a <= 0;
      b <= 0;
      w <= 0;
      lines <= 0;
    end else if (disp_en_out) begin
      if (b != 0) begin
        act_len <= a;
        blank_len <= b;
        sw_len <= w;
        lines <= lines + 1;
        a <= 1;
        b <= 0;
        w <= 0;
      end else begin
        a <= a + 1;
      end
    end else begin
      if (horiz_sync_out == pol) begin
        if (w == 0) begin
          ss_off <= b;
        end
        w <= w + 1;
      end
      b <= b + 1;
    end
  end
endmodule // cthtg_video_sink

// >>> sim/cthtg_top_test.sv
// testbench: register access, line geometry in every output mode, line count
`timescale 1ns/10ps
module cthtg_top_test;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  cthtg_pkg::cthtg_bus_req_t bus_req = '0;
  logic [7:0] rd_data;
  logic horiz_sync_out;
  logic disp_en_out;
  logic line_start_out;
  logic pol = 1'b0;
  logic [7:0] got;
  int act_len, blank_len, ss_off, sw_len, lines;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  cthtg_top uut (.ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req), .rd_data(rd_data),
    .horiz_sync_out(horiz_sync_out), .disp_en_out(disp_en_out),
    .line_start_out(line_start_out));
  cthtg_video_sink sink (.ref_clk(ref_clk), .rstn(rstn), .horiz_sync_out(horiz_sync_out),
    .disp_en_out(disp_en_out), .pol(pol), .act_len(act_len), .blank_len(blank_len),
    .ss_off(ss_off), .sw_len(sw_len), .lines(lines));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  // runaway guard: the whole sequence needs well under 5000 cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      tally_and_finish();
    end
  end
  task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: read %h expected %h", $time, g, e);
    end
  endtask
  task automatic check_len(input int g, input int e);
    n_tests++;
    if (g != e) begin
      fails++;
      $display("Error at %0t: length %0d expected %0d", $time, g, e);
    end
  endtask
  // writes leave the strobe up so they can run back to back; bus_idle drops it
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
  endtask
  task automatic bus_idle();
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 got = rd_data;
  endtask
  task automatic wait_lines(input int n);
    int l0;
    l0 = lines;
    for (int i = 0; i < 2000 && lines < l0 + n; i++) @(posedge ref_clk);
  endtask
  task automatic test_regs();
    logic [7:0] addrs [8] = '{cthtg_pkg::ADDR_HACT, cthtg_pkg::ADDR_HBLANK, cthtg_pkg::ADDR_HSS,
      cthtg_pkg::ADDR_HSW_POL, cthtg_pkg::ADDR_VH_LO, cthtg_pkg::ADDR_VH_HI,
      cthtg_pkg::ADDR_OUT_CTRL, cthtg_pkg::ADDR_MODE};
    foreach (addrs[i]) begin
      rd_reg(addrs[i]);
      check_byte(got, cthtg_pkg::REG_RESET);
    end
    wr_reg(cthtg_pkg::ADDR_OUT_CTRL, 8'hFF);
    rd_reg(cthtg_pkg::ADDR_OUT_CTRL);
    check_byte(got, cthtg_pkg::OUT_CTRL_MASK);
    wr_reg(8'h51, 8'hFF);
    rd_reg(8'h51);
    check_byte(got, 8'h00);
    // open blanking first so the mode probe below never makes a clipped sync pulse
    wr_reg(cthtg_pkg::ADDR_HBLANK, 8'h04);
    rd_reg(cthtg_pkg::ADDR_HBLANK);
    check_byte(got, 8'h04);
    wr_reg(cthtg_pkg::ADDR_MODE, 8'h03);
    rd_reg(cthtg_pkg::ADDR_MODE);
    check_byte(got, 8'h03);
    wr_reg(cthtg_pkg::ADDR_OUT_CTRL, 8'h00);
    wr_reg(cthtg_pkg::ADDR_MODE, 8'h00);
    bus_idle();
    $display("register test done");
  endtask
  // geometry 1/4/1 keeps blanking at least 3 units in crt and covers start plus width
  task automatic test_geom(input logic tv, input logic pl, input logic d16, input logic hp);
    int hb;
    int hs;
    int hw;
    hb = 4;
    hs = 1;
    hw = tv ? 0 : 1;
    for (int i = 0; i < 2000 && line_start_out !== 1'b1; i++) @(posedge ref_clk);
    pol <= hp;
    wr_reg(cthtg_pkg::ADDR_HACT, 8'h01);
    wr_reg(cthtg_pkg::ADDR_HBLANK, 8'(hb));
    wr_reg(cthtg_pkg::ADDR_HSS, 8'(hs));
    wr_reg(cthtg_pkg::ADDR_HSW_POL, {hp, 3'b000, 4'(hw)});
    wr_reg(cthtg_pkg::ADDR_OUT_CTRL, {7'h00, pl});
    wr_reg(cthtg_pkg::ADDR_MODE, {6'h00, d16, tv});
    bus_idle();
    wait_lines(2);
    check_len(act_len, (1 + 1) * 8);
    check_len(blank_len, !tv ? (hb + 1) * 8 : hb * 8 + (pl ? 7 : 6));
    check_len(ss_off, !tv ? hs * 8 + (d16 ? 5 : 3) : (hs + 1) * 8 - (d16 ? 5 : 7));
    check_len(sw_len, (hw + 1) * 8);
    $display("geometry test done tv=%0d pal=%0d d16=%0d pol=%0d", tv, pl, d16, hp);
  endtask
  task automatic test_lines();
    logic [7:0] mx;
    logic [7:0] ln;
    mx = 8'h00;
    wr_reg(cthtg_pkg::ADDR_VH_LO, 8'h02);
    wr_reg(cthtg_pkg::ADDR_VH_HI, 8'h00);
    bus_idle();
    repeat (8) begin
      wait_lines(1);
      rd_reg(cthtg_pkg::ADDR_LINE_LO);
      ln = got;
      if (ln > mx) mx = ln;
      rd_reg(cthtg_pkg::ADDR_STATUS);
      check_byte({7'h00, got[cthtg_pkg::ST_LAST_LINE_BIT]}, {7'h00, ln == 8'h02});
    end
    check_byte(mx, 8'h02);
    $display("line count test done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    test_regs();
    test_geom(1'b0, 1'b0, 1'b0, 1'b1);
    test_geom(1'b0, 1'b0, 1'b1, 1'b1);
    test_geom(1'b0, 1'b0, 1'b0, 1'b0);
    test_geom(1'b1, 1'b0, 1'b0, 1'b0);
    test_geom(1'b1, 1'b0, 1'b1, 1'b0);
    test_geom(1'b1, 1'b1, 1'b0, 1'b0);
    test_geom(1'b1, 1'b1, 1'b1, 1'b0);
    test_lines();
    tally_and_finish();
  end
endmodule // cthtg_top_test
bind cthtg_top cthtg_checker chk (.ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req),
  .rd_data(rd_data), .horiz_sync_out(horiz_sync_out), .disp_en_out(disp_en_out),
  .line_start_out(line_start_out));
